//--- core/pef_event_flag_registers.sv
// Purpose: latched event flags, masks, combined interrupt and output voltage settings
// Assumes: an external serial engine issues one-cycle read and write requests
// Notes:   undervoltage lockout acts like reset on every register here except the synchroniser and edge detector flops
`timescale 1ns/1ps
`include "pef_map.svh"

module pef_event_flag_registers
  import pef_pkg::*;
#(
  parameter bit ALT_VARIANT = 1'b0
)
(
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       undervoltage_lockout_in,
  input  wire pef_req_t   req_in,
  input  wire logic       charger_sleep_state_in,
  input  wire logic       charger_reset_state_in,
  input  wire logic       charger_idle_state_in,
  input  wire logic       charger_precharge_state_in,
  input  wire logic       charger_constant_current_voltage_state_in,
  input  wire logic       charger_linear_mode_state_in,
  input  wire logic       charger_fault_flag_in,
  input  wire logic       thermal_suspend_indicator_in,
  input  wire logic       general_pin_3_in,
  input  wire logic       general_pin_2_in,
  input  wire logic       general_pin_1_in,
  input  wire logic       general_pin_0_in,
  input  wire logic       buck_not_power_good_in,
  input  wire logic       linear_reg_not_power_good_in,
  input  wire logic       push_button_status_in,
  output pef_rsp_t        rsp_out,
  output logic            irq_out,
  output logic [5:0]      buck_voltage_setting_out,
  output logic [5:0]      linear_reg_voltage_setting_out,
  output logic            pg_reset_out
);

  localparam int NPIN = 15;

  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  logic            undervoltage_lockout_meta_reg;
  logic            undervoltage_lockout_sync_reg;
  logic            clr_all;
  logic [7:0]      chg_set;
  logic [7:0]      gpw_set;
  logic            rd_chg;
  logic            rd_gpw;
  logic [7:0]      chg_flags_reg;
  logic [7:0]      chg_flags_next;
  logic [7:0]      gpw_flags_reg;
  logic [7:0]      gpw_flags_next;
  logic [7:0]      chg_mask_reg;
  logic [7:0]      gpw_mask_reg;
  logic [5:0]      buck_vset_reg;
  logic [5:0]      ldo_vset_reg;
  logic [5:0]      ldo_wr_code;
  logic            wr_buck;
  logic            wr_ldo;
  logic [7:0]      rd_mux;
  logic            irq_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] pef_code_mv(input logic [5:0] code);
    pef_code_mv = `PEF_VSET_BASE_MV + `PEF_VSET_STEP_MV * {26'h0, code};
  endfunction

  function automatic logic pef_step_too_big(input logic [5:0] old_code,
                                            input logic [5:0] new_code);
    pef_step_too_big = (pef_code_mv(new_code) * 32'd100)
                     > (pef_code_mv(old_code) * `PEF_STEP_LIMIT_PCT);
  endfunction

  function automatic logic pef_hit(input logic [7:0] addr, input logic [7:0] ofs);
    pef_hit = (addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  assign pins = {charger_sleep_state_in,
                 charger_reset_state_in,
                 charger_idle_state_in,
                 charger_precharge_state_in,
                 charger_constant_current_voltage_state_in,
                 charger_linear_mode_state_in,
                 charger_fault_flag_in,
                 thermal_suspend_indicator_in,
                 general_pin_3_in,
                 general_pin_2_in,
                 general_pin_1_in,
                 general_pin_0_in,
                 buck_not_power_good_in,
                 linear_reg_not_power_good_in,
                 push_button_status_in};

  pef_edge_detect #(
    .WIDTH (NPIN)
  ) u_edges (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (pins),
    .rise_out   (rise),
    .fall_out   (fall)
  );

  // lockout level crosses in through two flops
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      undervoltage_lockout_meta_reg <= 1'b0;
      undervoltage_lockout_sync_reg <= 1'b0;
    end
    else
    begin
      undervoltage_lockout_meta_reg <= undervoltage_lockout_in;
      undervoltage_lockout_sync_reg <= undervoltage_lockout_meta_reg;
    end
  end

  assign clr_all = sys_rst_in | undervoltage_lockout_sync_reg;

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  assign chg_set = rise[14:7];
  assign gpw_set = {rise[6:3] | fall[6:3],
                    rise[2],
                    rise[1],
                    rise[0] | fall[0],
                    1'b0};

  assign rd_chg = req_in.rd & pef_hit(req_in.addr, `PEF_OFS_CHG_FLAGS);
  assign rd_gpw = req_in.rd & pef_hit(req_in.addr, `PEF_OFS_GPW_FLAGS);

  // ----------------------------------------------------------------
  // flag registers: clear on read, a new edge wins over the clear
  // ----------------------------------------------------------------
  always_comb
  begin
    chg_flags_next = (rd_chg ? `PEF_FLAGS_RST : chg_flags_reg) | chg_set;
    gpw_flags_next = (rd_gpw ? `PEF_FLAGS_RST : gpw_flags_reg) | gpw_set;
    gpw_flags_next[`PEF_GPW_UNUSED_BIT] = 1'b0;
  end

  always_ff @(posedge mclk_in)
  begin
    if (clr_all)
    begin
      chg_flags_reg <= `PEF_FLAGS_RST;
      gpw_flags_reg <= `PEF_FLAGS_RST;
    end
    else
    begin
      chg_flags_reg <= chg_flags_next;
      gpw_flags_reg <= gpw_flags_next;
    end
  end

  // ----------------------------------------------------------------
  // mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (clr_all)
    begin
      chg_mask_reg <= `PEF_MASK_RST;
      gpw_mask_reg <= `PEF_MASK_RST;
    end
    else if (req_in.wr && pef_hit(req_in.addr, `PEF_OFS_CHG_MASK))
    begin
      chg_mask_reg <= req_in.wdata;
    end
    else if (req_in.wr && pef_hit(req_in.addr, `PEF_OFS_GPW_MASK))
    begin
      // bit 0 has no event behind it and stays set
      gpw_mask_reg <= {req_in.wdata[7:1], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // output voltage settings
  // ----------------------------------------------------------------
  assign wr_buck = req_in.wr & pef_hit(req_in.addr, `PEF_OFS_BUCK_VSET);
  assign wr_ldo  = req_in.wr & pef_hit(req_in.addr, `PEF_OFS_LDO_VSET);

  // linear regulator codes past 3.3 V are held at 3.3 V; buck codes are stored as written
  assign ldo_wr_code = (req_in.wdata[5:0] > `PEF_VSET_MAX_CODE) ?
                       `PEF_VSET_MAX_CODE : req_in.wdata[5:0];

  always_ff @(posedge mclk_in)
  begin
    if (clr_all)
    begin
      buck_vset_reg <= ALT_VARIANT ? `PEF_BUCK_VSET_ALT_RST : `PEF_BUCK_VSET_RST;
      ldo_vset_reg  <= `PEF_LDO_VSET_RST;
    end
    else if (wr_buck)
    begin
      buck_vset_reg <= req_in.wdata[5:0];
    end
    else if (wr_ldo)
    begin
      ldo_vset_reg <= ldo_wr_code;
    end
  end

  assign buck_voltage_setting_out       = buck_vset_reg;
  assign linear_reg_voltage_setting_out = ldo_vset_reg;

  // oversized upward step: comparator trips and requests reset; downward always fine
  always_ff @(posedge mclk_in)
  begin
    if (clr_all)
    begin
      pg_reset_out <= 1'b0;
    end
    else
    begin
      pg_reset_out <= (wr_buck && pef_step_too_big(buck_vset_reg, req_in.wdata[5:0]))
                   || (wr_ldo && pef_step_too_big(ldo_vset_reg, ldo_wr_code));
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb
  begin
    if (pef_hit(req_in.addr, `PEF_OFS_CHG_MASK))
      rd_mux = chg_mask_reg;
    else if (pef_hit(req_in.addr, `PEF_OFS_GPW_MASK))
      rd_mux = gpw_mask_reg;
    else if (pef_hit(req_in.addr, `PEF_OFS_CHG_FLAGS))
      rd_mux = chg_flags_reg;
    else if (pef_hit(req_in.addr, `PEF_OFS_GPW_FLAGS))
      rd_mux = gpw_flags_reg;
    else if (pef_hit(req_in.addr, `PEF_OFS_BUCK_VSET))
      rd_mux = {2'h0, buck_vset_reg};
    else if (pef_hit(req_in.addr, `PEF_OFS_LDO_VSET))
      rd_mux = {2'h0, ldo_vset_reg};
    else
      rd_mux = 8'h00;
  end

  always_ff @(posedge mclk_in)
  begin
    if (clr_all)
    begin
      rsp_out <= '0;
    end
    else
    begin
      rsp_out.valid <= req_in.rd;
      rsp_out.rdata <= req_in.rd ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // combined interrupt
  // ----------------------------------------------------------------
  assign irq_next = |(chg_flags_next & ~chg_mask_reg)
                  | |(gpw_flags_next & ~gpw_mask_reg);

  always_ff @(posedge mclk_in)
  begin
    if (clr_all)
    begin
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= irq_next;
    end
  end

endmodule

//--- core/pef_map.svh
// Purpose: register offsets, field positions, reset values for the event flag block
// Assumes: byte-wide registers at byte offsets on the serial register interface
// Notes:   voltage codes are 50 mV steps above 0.8 V
`ifndef PEF_MAP_SVH
`define PEF_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PEF_OFS_CHG_MASK      8'h0e
`define PEF_OFS_GPW_MASK      8'h0f
`define PEF_OFS_CHG_FLAGS     8'h11
`define PEF_OFS_GPW_FLAGS     8'h12
`define PEF_OFS_BUCK_VSET     8'h13
`define PEF_OFS_LDO_VSET      8'h14

// ----------------------------------------------------------------
// field positions in the gpio/power flag register
// ----------------------------------------------------------------
`define PEF_GPW_GPIO_LSB      4
`define PEF_GPW_BUCK_PG_BIT   3
`define PEF_GPW_LDO_PG_BIT    2
`define PEF_GPW_PB_BIT        1
`define PEF_GPW_UNUSED_BIT    0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PEF_FLAGS_RST         8'h00
`define PEF_MASK_RST          8'hff
`define PEF_BUCK_VSET_RST     6'h15
`define PEF_BUCK_VSET_ALT_RST 6'h16
`define PEF_LDO_VSET_RST      6'h15

// ----------------------------------------------------------------
// voltage code scale
// ----------------------------------------------------------------
`define PEF_VSET_BASE_MV      32'd800
`define PEF_VSET_STEP_MV      32'd50
`define PEF_VSET_MAX_CODE     6'h32
`define PEF_STEP_LIMIT_PCT    32'd108

`endif

//--- core/pef_pkg.sv
// Purpose: shared types of the event flag block
// Assumes: offsets and reset values come from pef_map.svh
// Notes:   types only
package pef_pkg;

  // ----------------------------------------------------------------
  // register access request from the serial interface engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pef_req_t;

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } pef_rsp_t;

endpackage

//--- core/pef_edge_detect.sv
// Purpose: two-stage synchroniser and edge detector for a group of pins
// Assumes: pins are asynchronous to mclk_in
// Notes:   edges are one-cycle pulses, two edges after the pin moves
`timescale 1ns/1ps
module pef_edge_detect
  import pef_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             mclk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] last_reg;

  // ----------------------------------------------------------------
  // synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise_out = sync_reg & ~last_reg;
  assign fall_out = ~sync_reg & last_reg;

endmodule

//--- tb/pef_host.sv
// Purpose: host model issuing register accesses
// Assumes: one-cycle rd/wr pulse, answer one cycle later
// Notes:   drives on the falling edge
`timescale 1ns/1ps
module pef_host
  import pef_pkg::*;
(
  input  wire logic     mclk_in,
  input  wire pef_rsp_t rsp_in,
  output pef_req_t      req_out
);
  initial req_out = '0;
  // ------
  // one access per call
  // ------
  task automatic access(input logic w, input logic [7:0] a, d, output pef_rsp_t r);
    @(negedge mclk_in);
    req_out = {~w, w, a, d};
    // answer stands only for the cycle after the taking edge
    @(negedge mclk_in);
    r = rsp_in;
    req_out = '0;
  endtask
endmodule

//--- tb/pef_chk_asserts.sv
// Purpose: port checker of the event flag block
// Assumes: mclk_in domain only
// Notes:   bound to the top module
`timescale 1ns/1ps
module pef_chk
  import pef_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  input  wire pef_req_t   req_in,
  input  wire pef_rsp_t   rsp_out,
  input  wire logic       irq_out,
  input  wire logic [5:0] buck_voltage_setting_out,
  input  wire logic [5:0] linear_reg_voltage_setting_out,
  input  wire logic       pg_reset_out
);
  wire logic [5:0] buck = buck_voltage_setting_out;
  wire logic [5:0] ldo  = linear_reg_voltage_setting_out;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // ------
  // access sequences
  // ------
  sequence s_wr(logic [7:0] a);
    req_in.wr && req_in.addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    req_in.rd && req_in.addr == a;
  endsequence
  // ------
  // properties
  // ------
  property p_ans;
    req_in.rd |=> rsp_out.valid;
  endproperty
  property p_bit0;
    s_rd(8'h12) |=> rsp_out.rdata[0] == 1'b0;
  endproperty
  property p_ldo_max;
    ldo <= 6'h32;
  endproperty
  property p_ldo_wr;
    s_wr(8'h14) |=> ldo == ($past(req_in.wdata[5:0]) > 6'h32 ? 6'h32 : $past(req_in.wdata[5:0]));
  endproperty
  property p_buck_wr;
    s_wr(8'h13) |=> buck == $past(req_in.wdata[5:0]);
  endproperty
  property p_pg_cause;
    pg_reset_out |-> $past(req_in.wr);
  endproperty
  property p_pg_lo;
    s_wr(8'h13) ##0 req_in.wdata[5:0] <= buck |=> !pg_reset_out;
  endproperty
  property p_pg_hi;
    s_wr(8'h13) ##0 (32'd800 + 32'd50 * req_in.wdata[5:0]) * 100 >
      (32'd800 + 32'd50 * buck) * 108 |=> pg_reset_out;
  endproperty
  property p_rst;
    disable iff (1'b0) sys_rst_in |=> !irq_out && !pg_reset_out && !rsp_out.valid;
  endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  a_bit0: assert property (p_bit0) else $error("unused bit set");
  a_ldo_max: assert property (p_ldo_max) else $error("ldo code too high");
  a_ldo_wr: assert property (p_ldo_wr) else $error("ldo write lost");
  a_buck_wr: assert property (p_buck_wr) else $error("buck write lost");
  a_pg_cause: assert property (p_pg_cause) else $error("pg pulse without write");
  a_pg_lo: assert property (p_pg_lo) else $error("pg pulse on lowering");
  a_pg_hi: assert property (p_pg_hi) else $error("big step without pg");
  a_rst: assert property (p_rst) else $error("outputs not cleared");
endmodule
bind pef_event_flag_registers pef_chk i_chk (.mclk_in, .sys_rst_in, .req_in, .rsp_out, .irq_out,
  .buck_voltage_setting_out, .linear_reg_voltage_setting_out, .pg_reset_out);

//--- tb/tb.sv
// Purpose: register level tests of the event flag block
// Assumes: flags settle within four cycles of a pin change
// Notes:   ev holds charger bits 7..0 then flag bits 7..1
`timescale 1ns/1ps
module tb
  import pef_pkg::*;
;
  logic        mclk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        undervoltage_lockout = 1'b0;
  logic [14:0] ev = '0;
  pef_req_t    req;
  pef_rsp_t    rsp;
  pef_rsp_t    r;
  logic        irq;
  logic        pg;
  logic [5:0]  buck;
  logic [5:0]  ldo;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #2.5 mclk_in = ~mclk_in;

  pef_event_flag_registers i_dut (
    .mclk_in, .sys_rst_in, .undervoltage_lockout_in(undervoltage_lockout), .req_in(req),
    .charger_sleep_state_in(ev[14]), .charger_reset_state_in(ev[13]),
    .charger_idle_state_in(ev[12]), .charger_precharge_state_in(ev[11]),
    .charger_constant_current_voltage_state_in(ev[10]), .charger_linear_mode_state_in(ev[9]),
    .charger_fault_flag_in(ev[8]), .thermal_suspend_indicator_in(ev[7]),
    .general_pin_3_in(ev[6]), .general_pin_2_in(ev[5]), .general_pin_1_in(ev[4]),
    .general_pin_0_in(ev[3]), .buck_not_power_good_in(ev[2]),
    .linear_reg_not_power_good_in(ev[1]), .push_button_status_in(ev[0]), .rsp_out(rsp),
    .irq_out(irq), .buck_voltage_setting_out(buck), .linear_reg_voltage_setting_out(ldo),
    .pg_reset_out(pg));
  pef_host i_host (.mclk_in, .rsp_in(rsp), .req_out(req));
  // ------
  // helpers
  // ------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic wr(input logic [7:0] a, d);
    i_host.access(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, e);
    i_host.access(1'b0, a, 8'h00, r);
    chk("valid", {7'h0, r.valid}, 8'h01);
    chk($sformatf("reg %h", a), r.rdata, e);
  endtask
  // pin up then down, flag checked each way
  task automatic edge_chk(input logic [7:0] a, input int k, input logic both);
    int i;
    i = (a == 8'h11) ? k + 7 : k - 1;
    ev[i] = 1'b1;
    idle(4);
    rd(a, 8'h01 << k);
    rd(a, 8'h00);
    ev[i] = 1'b0;
    idle(4);
    rd(a, both ? 8'h01 << k : 8'h00);
  endtask
  // ------
  // hang guard
  // ------
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      stop_test();
    end
  end
  // ------
  // tests
  // ------
  initial
  begin
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    sys_rst_in = 1'b0;
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h00);
    rd(8'h0e, 8'hff);
    rd(8'h0f, 8'hff);
    rd(8'h13, 8'h15);
    rd(8'h14, 8'h15);
    rd(8'h20, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 8; k++)
      edge_chk(8'h11, k, 1'b0);
    for (int k = 1; k < 8; k++)
      edge_chk(8'h12, k, k != 2 && k != 3);
    $display("test edges done");
    wr(8'h0e, 8'h7f);
    wr(8'h0f, 8'hfd);
    wr(8'h11, 8'hff);
    ev[13] = 1'b1;
    idle(4);
    chk("irq", {7'h0, irq}, 8'h00);
    ev[14] = 1'b1;
    idle(4);
    chk("irq", {7'h0, irq}, 8'h01);
    rd(8'h11, 8'hc0);
    chk("irq", {7'h0, irq}, 8'h00);
    ev[6] = 1'b1;
    ev[0] = 1'b1;
    idle(4);
    chk("irq", {7'h0, irq}, 8'h01);
    rd(8'h12, 8'h82);
    ev[6] = 1'b0;
    idle(4);
    chk("irq", {7'h0, irq}, 8'h00);
    rd(8'h12, 8'h80);
    $display("test masks done");
    wr(8'h14, 8'h3f);
    chk("ldo", {2'b0, ldo}, 8'h32);
    chk("pg", {7'h0, pg}, 8'h01);
    wr(8'h14, 8'h00);
    chk("pg", {7'h0, pg}, 8'h00);
    wr(8'h13, 8'h09);
    chk("pg", {7'h0, pg}, 8'h00);
    wr(8'h13, 8'h0b);
    chk("pg", {7'h0, pg}, 8'h00);
    chk("buck", {2'b0, buck}, 8'h0b);
    wr(8'h13, 8'h1a);
    chk("pg", {7'h0, pg}, 8'h01);
    $display("test voltage done");
    ev[12] = 1'b1;
    idle(4);
    undervoltage_lockout = 1'b1;
    idle(4);
    undervoltage_lockout = 1'b0;
    idle(4);
    rd(8'h11, 8'h00);
    rd(8'h0e, 8'hff);
    rd(8'h13, 8'h15);
    $display("test lockout done");
    stop_test();
  end
endmodule
